// file: cmpblk_defines.svh
// Register offsets, field positions and reset values of the comparator
// blanking and mask block. Definitions only; included by its bare name.
`ifndef CMPBLK_DEFINES_SVH
`define CMPBLK_DEFINES_SVH

// -----------------------------------------------------------------------
// Register byte offsets on the APB
// -----------------------------------------------------------------------
`define CMPBLK_OFS_CTRL 8'h00
`define CMPBLK_OFS_MSRC 8'h04
`define CMPBLK_OFS_MGATE 8'h08
`define CMPBLK_OFS_OUT 8'h0c

// -----------------------------------------------------------------------
// Channel control fields
// -----------------------------------------------------------------------
`define CMPBLK_CTRL_POSREF 4
`define CMPBLK_CTRL_NEG_LO 0
`define CMPBLK_CTRL_WMASK 16'h0013

// -----------------------------------------------------------------------
// Mask source fields
// -----------------------------------------------------------------------
`define CMPBLK_MSRC_A_LO 0
`define CMPBLK_MSRC_B_LO 4
`define CMPBLK_MSRC_C_LO 8
`define CMPBLK_MSRC_WMASK 16'h0fff

// -----------------------------------------------------------------------
// Mask gating fields
// -----------------------------------------------------------------------
`define CMPBLK_MG_LEVEL 15
`define CMPBLK_MG_OR_CT 13
`define CMPBLK_MG_OR_CI 12
`define CMPBLK_MG_OR_BT 11
`define CMPBLK_MG_OR_BI 10
`define CMPBLK_MG_OR_AT 9
`define CMPBLK_MG_OR_AI 8
`define CMPBLK_MG_ANDINV 7
`define CMPBLK_MG_ANDTRUE 6
`define CMPBLK_MG_AND_CT 5
`define CMPBLK_MG_AND_CI 4
`define CMPBLK_MG_AND_BT 3
`define CMPBLK_MG_AND_BI 2
`define CMPBLK_MG_AND_AT 1
`define CMPBLK_MG_AND_AI 0
`define CMPBLK_MG_WMASK 16'hbfff

`define CMPBLK_RESET_VAL 16'h0000

`endif

// file: cmpblk_pkg.sv
// Types shared by the comparator blanking and mask block.
// Assumes nothing beyond a SystemVerilog tool.
package cmpblk_pkg;

    // Negative input choice
    typedef enum logic [1:0] {
        CMPBLK_NEG_PIN_B = 2'h0,
        CMPBLK_NEG_PIN_C = 2'h1,
        CMPBLK_NEG_PIN_D = 2'h2,
        CMPBLK_NEG_BANDGAP = 2'h3
    } cmpblk_neg_sel_t;

    // Mask source codes; codes above gen3 high are reserved
    typedef enum logic [3:0] {
        CMPBLK_SRC_G1_LOW = 4'h0,
        CMPBLK_SRC_G1_HIGH = 4'h1,
        CMPBLK_SRC_G2_LOW = 4'h2,
        CMPBLK_SRC_G2_HIGH = 4'h3,
        CMPBLK_SRC_G3_LOW = 4'h4,
        CMPBLK_SRC_G3_HIGH = 4'h5
    } cmpblk_src_t;

    typedef logic [15:0] cmpblk_reg_t;

endpackage : cmpblk_pkg

// file: cmpblk_src_mux.sv
// One mask source selector: picks one of six generator outputs.
// Assumes generator outputs are synchronous to clk.
`timescale 1ns/100ps
module cmpblk_src_mux (
    input wire logic [5:0] gen_outputs,
    input wire logic [3:0] sel,
    output logic mask_signal
);
    import cmpblk_pkg::*;

    // Reserved codes give a quiet (low) mask rather than an unknown
    always_comb begin
        case (cmpblk_src_t'(sel))
            CMPBLK_SRC_G1_LOW: mask_signal = gen_outputs[0];
            CMPBLK_SRC_G1_HIGH: mask_signal = gen_outputs[1];
            CMPBLK_SRC_G2_LOW: mask_signal = gen_outputs[2];
            CMPBLK_SRC_G2_HIGH: mask_signal = gen_outputs[3];
            CMPBLK_SRC_G3_LOW: mask_signal = gen_outputs[4];
            CMPBLK_SRC_G3_HIGH: mask_signal = gen_outputs[5];
            default: mask_signal = 1'b0;
        endcase
    end
endmodule : cmpblk_src_mux

// file: cmpblk_gate_net.sv
// AND/OR gate network combining three mask signals into one blank level.
// Assumes gating bits come straight from the mask gating register.
`timescale 1ns/100ps
`include "cmpblk_defines.svh"
module cmpblk_gate_net (
    input wire logic [15:0] gating,
    input wire logic mask_a_signal,
    input wire logic mask_b_signal,
    input wire logic mask_c_signal,
    output logic and_gate_output,
    output logic blank
);
    import cmpblk_pkg::*;

    logic [5:0] and_en;
    logic [5:0] and_terms;
    logic [5:0] or_en;
    logic [5:0] or_terms;
    logic and_any;

    assign and_terms = {mask_c_signal, ~mask_c_signal, mask_b_signal,
                        ~mask_b_signal, mask_a_signal, ~mask_a_signal};
    assign or_terms = and_terms;
    assign and_en = gating[`CMPBLK_MG_AND_CT:`CMPBLK_MG_AND_AI];
    assign or_en = gating[`CMPBLK_MG_OR_CT:`CMPBLK_MG_OR_AI];
    assign and_any = |and_en;

    // Only enabled inputs take part; an empty AND reads low so it cannot
    // blank the output through gating bit 6
    assign and_gate_output = and_any & (&(and_terms | ~and_en));

    assign blank = (|(or_terms & or_en))
        | (gating[`CMPBLK_MG_ANDINV] & ~and_gate_output)
        | (gating[`CMPBLK_MG_ANDTRUE] & and_gate_output);
endmodule : cmpblk_gate_net

// file: cmpblk_top.sv
// Comparator channel input select and blanking/mask logic, APB slave.
// Assumes analog selects are drawn as digital select lines, the compare
// result arrives synchronous to clk, and one APB master drives the bus.
//
// What this block does
// - Control bit 4 picks reference (1) or pin A (0) for positive input.
// - Negative select: 11 band-gap, 10 pin D, 01 pin C, 00 pin B.
// - Mask C source bits 11-8 pick one of six generator outputs.
// - Mask B source bits 7-4 use the same encoding, 0010 is gen2 low.
// - Mask A source bits 3-0 use the same encoding as mask C.
// - Gating bit 15 chooses high or low level while masking.
// - Gating bits 13, 11, 9 connect true C, B, A to the OR gate.
// - Gating bits 12, 10, 8 connect inverted C, B, A to the OR gate.
// - Gating bit 7 feeds the inverted AND output to the OR gate.
// - Gating bits 5 and 4 connect true and inverted C to the AND gate.
// - Gating bits 3 to 0 connect true/inverted B and A to AND gate.
`timescale 1ns/100ps
`include "cmpblk_defines.svh"
module cmpblk_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic gen1_low_output,
    input wire logic gen1_high_output,
    input wire logic gen2_low_output,
    input wire logic gen2_high_output,
    input wire logic gen3_low_output,
    input wire logic gen3_high_output,
    input wire logic compare_result,
    output logic pos_input_ref_select,
    output cmpblk_pkg::cmpblk_neg_sel_t neg_input_channel_select,
    output logic mask_a_signal,
    output logic mask_b_signal,
    output logic mask_c_signal,
    output logic blank_active,
    output logic blanked_output
);
    import cmpblk_pkg::*;

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    cmpblk_reg_t channel_control;
    cmpblk_reg_t mask_source_select;
    cmpblk_reg_t mask_gating_control;

    // -------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------
    logic access;
    logic wr_en;
    logic rd_en;
    logic hit_ctrl;
    logic hit_msrc;
    logic hit_mgate;
    logic hit_out;
    logic hit_any;
    cmpblk_reg_t wdata16;
    cmpblk_reg_t rd_mux;

    // Zero-wait slave: the access phase completes in its first cycle
    assign access = psel & penable;
    assign hit_ctrl = (paddr == `CMPBLK_OFS_CTRL);
    assign hit_msrc = (paddr == `CMPBLK_OFS_MSRC);
    assign hit_mgate = (paddr == `CMPBLK_OFS_MGATE);
    assign hit_out = (paddr == `CMPBLK_OFS_OUT);
    assign hit_any = hit_ctrl | hit_msrc | hit_mgate | hit_out;
    assign wr_en = access & pwrite & hit_any;
    assign rd_en = psel & ~penable & ~pwrite;
    assign wdata16 = pwdata[15:0];

    assign rd_mux = hit_ctrl ? channel_control :
                    hit_msrc ? mask_source_select :
                    hit_mgate ? mask_gating_control :
                    hit_out ? {14'h0000, blank_active, blanked_output} :
                    `CMPBLK_RESET_VAL;

    // Status word is read-only; writes there are dropped without error
    always_ff @(posedge clk) begin
        if (srst) begin
            channel_control <= `CMPBLK_RESET_VAL;
            mask_source_select <= `CMPBLK_RESET_VAL;
            mask_gating_control <= `CMPBLK_RESET_VAL;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                channel_control <= wdata16 & `CMPBLK_CTRL_WMASK;
            end
            if (hit_msrc) begin
                mask_source_select <= wdata16 & `CMPBLK_MSRC_WMASK;
            end
            if (hit_mgate) begin
                mask_gating_control <= wdata16 & `CMPBLK_MG_WMASK;
            end
        end
    end

    // -------------------------------------------------------------------
    // Bus answer
    // -------------------------------------------------------------------
    // Read data is captured in setup so it stands registered in access
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_any;
            if (rd_en) begin
                prdata <= {16'h0000, rd_mux};
            end
        end
    end

    // -------------------------------------------------------------------
    // Mask source selection
    // -------------------------------------------------------------------
    logic [5:0] gen_outputs;
    logic next_mask_a;
    logic next_mask_b;
    logic next_mask_c;

    assign gen_outputs = {gen3_high_output, gen3_low_output,
                          gen2_high_output, gen2_low_output,
                          gen1_high_output, gen1_low_output};

    cmpblk_src_mux u_src_a (
        .gen_outputs(gen_outputs),
        .sel(mask_source_select[`CMPBLK_MSRC_A_LO +: 4]),
        .mask_signal(next_mask_a)
    );

    cmpblk_src_mux u_src_b (
        .gen_outputs(gen_outputs),
        .sel(mask_source_select[`CMPBLK_MSRC_B_LO +: 4]),
        .mask_signal(next_mask_b)
    );

    cmpblk_src_mux u_src_c (
        .gen_outputs(gen_outputs),
        .sel(mask_source_select[`CMPBLK_MSRC_C_LO +: 4]),
        .mask_signal(next_mask_c)
    );

    // -------------------------------------------------------------------
    // Gate network and blanking
    // -------------------------------------------------------------------
    logic next_blank;
    logic next_blanked;

    cmpblk_gate_net u_gate (
        .gating(mask_gating_control),
        .mask_a_signal(next_mask_a),
        .mask_b_signal(next_mask_b),
        .mask_c_signal(next_mask_c),
        .and_gate_output(),
        .blank(next_blank)
    );

    // Blanking holds the output at the chosen level, never passes it
    assign next_blanked = next_blank ?
        mask_gating_control[`CMPBLK_MG_LEVEL] : compare_result;

    // Outputs registered: one clock of latency from any register, generator or compare change
    always_ff @(posedge clk) begin
        if (srst) begin
            pos_input_ref_select <= 1'b0;
            neg_input_channel_select <= CMPBLK_NEG_PIN_B;
            mask_a_signal <= 1'b0;
            mask_b_signal <= 1'b0;
            mask_c_signal <= 1'b0;
            blank_active <= 1'b0;
            blanked_output <= 1'b0;
        end else begin
            pos_input_ref_select <=
                channel_control[`CMPBLK_CTRL_POSREF];
            neg_input_channel_select <= cmpblk_neg_sel_t'(
                channel_control[`CMPBLK_CTRL_NEG_LO +: 2]);
            mask_a_signal <= next_mask_a;
            mask_b_signal <= next_mask_b;
            mask_c_signal <= next_mask_c;
            blank_active <= next_blank;
            blanked_output <= next_blanked;
        end
    end

endmodule : cmpblk_top

// file: cmpblk_top_chk.sv
// Assertions on the ports of the comparator blanking block.
// Assumes registers change only through APB writes seen on its ports.
`timescale 1ns/100ps
`include "cmpblk_defines.svh"
module cmpblk_top_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic gen1_low_output,
    input wire logic gen1_high_output,
    input wire logic gen2_low_output,
    input wire logic gen2_high_output,
    input wire logic gen3_low_output,
    input wire logic gen3_high_output,
    input wire logic compare_result,
    input wire logic pos_input_ref_select,
    input wire cmpblk_pkg::cmpblk_neg_sel_t neg_input_channel_select,
    input wire logic mask_a_signal,
    input wire logic mask_b_signal,
    input wire logic mask_c_signal,
    input wire logic blank_active,
    input wire logic blanked_output
);
    import cmpblk_pkg::*;
    logic [15:0] sh_c, sh_s, sh_g;
    logic [2:0] quiet;
    logic [54:0] v_q;
    wire [5:0] g = {gen3_high_output, gen3_low_output, gen2_high_output,
        gen2_low_output, gen1_high_output, gen1_low_output};
    wire [54:0] v = {sh_c, sh_s, sh_g, g, compare_result};
    wire wr = psel & penable & pwrite & pready;
    wire [15:0] wd = pwdata[15:0];
    wire ea = (sh_s[3:0] < 4'h6) & g[sh_s[2:0]];
    wire eb = (sh_s[7:4] < 4'h6) & g[sh_s[6:4]];
    wire ec = (sh_s[11:8] < 4'h6) & g[sh_s[10:8]];
    wire [5:0] ain = {ec, ~ec, eb, ~eb, ea, ~ea};
    wire eand = (|sh_g[5:0]) & (&(ain | ~sh_g[5:0]));
    wire eblank = |({ain, ~eand, eand} & sh_g[13:6]);
    // Compare only once every cause has been still for four cycles,
    // which hides the latency choice of each registered output
    wire q = quiet[2] & (v == v_q);
    always_ff @(posedge clk) begin
        v_q <= v;
        if (srst) begin
            sh_c <= 16'h0000;
            sh_s <= 16'h0000;
            sh_g <= 16'h0000;
            quiet <= 3'h0;
        end else begin
            if (wr && paddr == `CMPBLK_OFS_CTRL) sh_c <= wd & `CMPBLK_CTRL_WMASK;
            if (wr && paddr == `CMPBLK_OFS_MSRC) sh_s <= wd & `CMPBLK_MSRC_WMASK;
            if (wr && paddr == `CMPBLK_OFS_MGATE) sh_g <= wd & `CMPBLK_MG_WMASK;
            quiet <= (v != v_q) ? 3'h0 : (quiet[2] ? quiet : quiet + 3'h1);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_pos; q |-> pos_input_ref_select == sh_c[4]; endproperty
    a_pos: assert property (p_pos)
        else $error("positive input select wrong");
    property p_neg; q |-> neg_input_channel_select == sh_c[1:0]; endproperty
    a_neg: assert property (p_neg)
        else $error("negative input select wrong");
    property p_mc; q |-> mask_c_signal == ec; endproperty
    a_mc: assert property (p_mc)
        else $error("mask c wrong");
    property p_mb; q |-> mask_b_signal == eb; endproperty
    a_mb: assert property (p_mb)
        else $error("mask b wrong");
    property p_ma; q |-> mask_a_signal == ea; endproperty
    a_ma: assert property (p_ma)
        else $error("mask a wrong");
    property p_blk; q |-> blank_active == eblank; endproperty
    a_blk: assert property (p_blk)
        else $error("blank level wrong");
    property p_lvl; q && blank_active |-> blanked_output == sh_g[15];
    endproperty
    a_lvl: assert property (p_lvl)
        else $error("masked level wrong");
    property p_pass; q && !blank_active |-> blanked_output == compare_result;
    endproperty
    a_pass: assert property (p_pass)
        else $error("compare not passed through");
    property p_rst; disable iff (1'b0) srst |=> !blank_active &&
        !mask_a_signal && !mask_b_signal && !mask_c_signal; endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not cleared by reset");
endmodule : cmpblk_top_chk

// file: cmpblk_pwm_model.sv
// Stand-in for the six generator outputs used as mask sources.
// Assumes the bench asks for levels; outputs move on clk only.
`timescale 1ns/100ps
module cmpblk_pwm_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic [5:0] level_req,
    output logic [5:0] gen_out
);
    // Halted generator keeps all outputs low through reset
    always_ff @(posedge clk) begin
        gen_out <= srst ? 6'h00 : level_req;
    end
endmodule : cmpblk_pwm_model

// file: cmpblk_top_tb.sv
// Self-checking bench for the comparator blanking block.
// Assumes a wait-free APB slave and the generator model beside it.
`timescale 1ns/100ps
`include "cmpblk_defines.svh"
module cmpblk_top_tb;
    import cmpblk_pkg::*;
    logic clk, srst, psel, penable, pwrite, cmp, pready, pslverr, err;
    logic pos, ma, mb, mc, blk, bout;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] req, gl;
    cmpblk_neg_sel_t neg;
    int failures, samples_checked;
    cmpblk_pwm_model pwm_u (.clk(clk), .srst(srst), .level_req(req),
        .gen_out(gl));
    cmpblk_top dut_u (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gen1_low_output(gl[0]), .gen1_high_output(gl[1]),
        .gen2_low_output(gl[2]), .gen2_high_output(gl[3]),
        .gen3_low_output(gl[4]), .gen3_high_output(gl[5]),
        .compare_result(cmp), .pos_input_ref_select(pos),
        .neg_input_channel_select(neg), .mask_a_signal(ma),
        .mask_b_signal(mb), .mask_c_signal(mc), .blank_active(blk),
        .blanked_output(bout));
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // A slave that never answers is a mismatch, not a silent pass
        if (pready !== 1'b1) begin
            failures++;
            $display("CHECK FAILED pready expected 1 seen %b", pready);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : xfer
    task automatic chk(input string nm, input logic [31:0] e, s);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #400000;
        failures++;
        conclude();
    end
    initial begin
        {srst, psel, penable, pwrite, cmp} = 5'h10;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        req = 6'h00;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        xfer(1'b1, `CMPBLK_OFS_CTRL, 32'h0000_ffff);
        xfer(1'b0, `CMPBLK_OFS_CTRL, 32'h0);
        chk("control readback", 32'h0000_0013, rd);
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, `CMPBLK_OFS_CTRL, 32'(k + 16 * (k % 2)));
            chk("positive select", 32'(k % 2), 32'(pos));
            chk("negative select", 32'(k), 32'(neg));
        end
        xfer(1'b0, 8'h10, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        // Three fields get different codes so a swapped field shows
        for (int k = 0; k < 8; k++) begin
            xfer(1'b1, `CMPBLK_OFS_MSRC,
                32'(k + 16 * ((k + 2) % 8) + 256 * ((k + 4) % 8)));
            for (int j = 0; j < 6; j++) begin
                req <= 6'(1 << j);
                repeat (4) @(posedge clk);
                chk("masks c b a", 32'({(k + 4) % 8 == j, (k + 2) % 8 == j,
                    k == j}), 32'({mc, mb, ma}));
            end
        end
        xfer(1'b1, `CMPBLK_OFS_MSRC, 32'h0000_0420);
        for (int i = 0; i < 16; i++) begin
            xfer(1'b1, `CMPBLK_OFS_MGATE,
                32'((1 << i) | (i < 6 ? 64 : 0) | (i % 2 ? 32768 : 0)));
            for (int p = 0; p < 8; p++) begin
                req <= {1'b0, p[2], 1'b0, p[1], 1'b0, p[0]};
                cmp <= p[0] ^ p[2];
                // Long enough for the checker's quiet window to open
                repeat (8) @(posedge clk);
            end
        end
        xfer(1'b1, `CMPBLK_OFS_MGATE, 32'h0000_ffff);
        xfer(1'b0, `CMPBLK_OFS_MGATE, 32'h0);
        chk("gating readback", 32'h0000_bfff, rd);
        xfer(1'b1, `CMPBLK_OFS_MGATE, 32'h0000_8200);
        req <= 6'h01;
        cmp <= 1'b0;
        repeat (4) @(posedge clk);
        xfer(1'b0, `CMPBLK_OFS_OUT, 32'h0);
        chk("blanked status", 32'h3, rd);
        req <= 6'h00;
        cmp <= 1'b1;
        repeat (5) @(posedge clk);
        xfer(1'b0, `CMPBLK_OFS_OUT, 32'h0);
        chk("pass status", 32'h1, rd);
        // Reset in mid-run must clear fields that hold non-zero values
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, 8'(4 * i), 32'h0);
            chk("field after reset", 32'h0, rd);
        end
        chk("blank after reset", 32'h0, 32'(blk));
        conclude();
    end
endmodule : cmpblk_top_tb
bind cmpblk_top cmpblk_top_chk chk_u (.clk(clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .gen1_low_output(gen1_low_output),
    .gen1_high_output(gen1_high_output), .gen2_low_output(gen2_low_output),
    .gen2_high_output(gen2_high_output), .gen3_low_output(gen3_low_output),
    .gen3_high_output(gen3_high_output), .compare_result(compare_result),
    .pos_input_ref_select(pos_input_ref_select),
    .neg_input_channel_select(neg_input_channel_select),
    .mask_a_signal(mask_a_signal), .mask_b_signal(mask_b_signal),
    .mask_c_signal(mask_c_signal), .blank_active(blank_active),
    .blanked_output(blanked_output));
